/* sgmii_mgmt_pkg.sv */
// constants, types and register map for the management status slice
package sgmii_mgmt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int LINK_TIMER_NS = 1600000;
  localparam int CLK_PERIOD_NS = 100;
  // least time, so round up to whole cycles
  localparam int LINK_TIMER_CYCLES =
    (LINK_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ID_UPPER = 5'h02;
  localparam logic [4:0] REG_ID_LOWER = 5'h03;

  // ----------------------------------------------------------------
  // status register layout
  // ----------------------------------------------------------------
  localparam int ABILITY_HI = 15;
  localparam int ABILITY_LO = 9;
  localparam int EXT_STATUS_BIT = 8;
  localparam int UNIDIR_BIT = 7;
  localparam int PREAMBLE_SUPP_BIT = 6;
  localparam int AN_DONE_BIT = 5;
  localparam int RFAULT_BIT = 4;
  localparam int AN_ABLE_BIT = 3;
  localparam int LINK_BIT = 2;
  localparam int JABBER_BIT = 1;
  localparam int EXT_CAP_BIT = 0;
  // constant part: bits 8, 7, 6 and 3 set, all else clear
  localparam logic [15:0] STATUS_FIXED = 16'h01c8;

  // ----------------------------------------------------------------
  // identifier layout (values arbitrary, not a real maker)
  // ----------------------------------------------------------------
  localparam logic [21:0] ORG_ID_DEFAULT = 22'h2a5c31;
  localparam logic [5:0] MODEL_DEFAULT = 6'h15;
  localparam logic [3:0] REVISION_DEFAULT = 4'h3;
  localparam int ORG_UPPER_LO = 6;

  // ----------------------------------------------------------------
  // management frame fields
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [3:0] OP_LAST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h9;
  localparam logic [3:0] TA_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'hf;

  typedef enum {
    st_idle,
    st_start,
    st_op,
    st_addr,
    st_ta,
    st_data
  } frame_state_e;

  typedef struct packed {
    logic sync_status;
    logic an_enable;
    logic an_complete;
    logic remote_fault;
  } link_state_s;

  typedef logic [15:0] mgmt_word_t;

endpackage

/* mdc_edge.sv */
// rising edge detector for the management clock input
`timescale 1ns/10ps
module mdc_edge
  import sgmii_mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic core_rstn,
  input wire logic management_frame_clk,
  output logic rise
);

  logic mdc_q;

  // reset high so a clock already high is not seen as an edge
  always_ff @(posedge clk) begin
    if (!core_rstn) begin
      mdc_q <= 1'h1;
    end else begin
      mdc_q <= management_frame_clk;
    end
  end

  assign rise = management_frame_clk & ~mdc_q;

endmodule // mdc_edge

/* link_qualifier.sv */
// holds sync for one link timer interval after it is lost
`timescale 1ns/10ps
module link_qualifier
  import sgmii_mgmt_pkg::*;
#(
  parameter int unsigned timer_cycles = LINK_TIMER_CYCLES
)(
  input wire logic clk,
  input wire logic core_rstn,
  input wire logic sync_status,
  output logic sync_held
);

  logic [TIMER_W-1:0] loss_count;

  always_ff @(posedge clk) begin
    if (!core_rstn) begin
      loss_count <= '0;
      sync_held <= 1'h0;
    end else if (sync_status) begin
      loss_count <= '0;
      sync_held <= 1'h1;
    end else if (sync_held) begin
      // drop only after a full interval of loss
      if (loss_count == TIMER_W'(timer_cycles - 1)) begin
        loss_count <= '0;
        sync_held <= 1'h0;
      end else begin
        loss_count <= loss_count + 1'h1;
      end
    end
  end

  a_sync_hold_time: assert property (
    @(posedge clk) disable iff (!core_rstn)
    sync_held && !sync_status && loss_count != TIMER_W'(timer_cycles - 1)
    |=> sync_held)
    else $error("sync dropped before link timer expired");

endmodule // link_qualifier

/* sgmii_mgmt_status_id_regs.sv */
// status and identifier registers behind the management serial port
//
// Notes on behaviour
// - status bits 15 to 9 read zero
// - bit 8 reads one, extended status present
// - bit 7 reads one, writes ignored
// - bit 6 reads one, preambleless frames accepted
// - bit 5 shows negotiation complete, resets zero
// - bit 4 remote fault, clears on read
// - bit 3 reads one, negotiation capable
// - bit 2 latches low, read reloads it
// - link high needs sync and, when negotiation is enabled, negotiation done
// - link low on no sync or lost sync
// - link drops after full link timer loss
// - bit 1 jabber reads zero
// - bit 0 extended capability reads zero
// - identifier registers return fixed constants
// - undefined addresses read zero, read-only
// - any reset source restores all defaults
`timescale 1ns/10ps
module sgmii_mgmt_status_id_regs
  import sgmii_mgmt_pkg::*;
#(
  parameter int unsigned link_timer_cycles = LINK_TIMER_CYCLES,
  parameter logic [21:0] org_id = ORG_ID_DEFAULT,
  parameter logic [5:0] model_number = MODEL_DEFAULT,
  parameter logic [3:0] revision = REVISION_DEFAULT
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_lock,
  input wire logic soft_reset,
  input wire logic [4:0] phy_address,
  input wire link_state_s link_in,
  input wire logic management_frame_clk,
  input wire logic management_frame_in,
  output logic management_frame_out,
  output logic management_frame_oe,
  output logic link_status,
  output logic remote_fault,
  output logic an_done
);

  // ----------------------------------------------------------------
  // reset and link qualification
  // ----------------------------------------------------------------
  logic core_rstn;
  logic mdc_rise;
  logic sync_held;
  logic link_ok;

  // all three sources restore every default
  assign core_rstn = resetn & clk_lock & ~soft_reset;

  mdc_edge u_mdc_edge (
    .clk(clk),
    .core_rstn(core_rstn),
    .management_frame_clk(management_frame_clk),
    .rise(mdc_rise)
  );

  link_qualifier #(
    .timer_cycles(link_timer_cycles)
  ) u_link_qualifier (
    .clk(clk),
    .core_rstn(core_rstn),
    .sync_status(link_in.sync_status),
    .sync_held(sync_held)
  );

  // negotiation only gates the link when enabled
  assign link_ok = sync_held & (~link_in.an_enable | link_in.an_complete);

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  frame_state_e state;
  logic [3:0] bit_count;
  logic [1:0] opcode;
  logic [9:0] addr_shift;
  logic [4:0] reg_addr;
  logic is_read;
  mgmt_word_t read_shift;
  mgmt_word_t read_word;
  logic read_done;
  logic [9:0] next_addr;

  assign next_addr = {addr_shift[8:0], management_frame_in};

  always_ff @(posedge clk) begin
    if (!core_rstn) begin
      state <= st_idle;
      bit_count <= '0;
      opcode <= '0;
      addr_shift <= '0;
      reg_addr <= '0;
      is_read <= 1'h0;
    end else if (mdc_rise) begin
      case (state)
        // preamble is optional, a zero starts the frame
        st_idle: begin
          if (!management_frame_in) begin
            state <= st_start;
          end
        end
        st_start: begin
          state <= management_frame_in ? st_op : st_idle;
          bit_count <= '0;
        end
        st_op: begin
          opcode <= {opcode[0], management_frame_in};
          bit_count <= bit_count + 4'h1;
          if (bit_count == OP_LAST) begin
            state <= st_addr;
            bit_count <= '0;
          end
        end
        st_addr: begin
          addr_shift <= next_addr;
          bit_count <= bit_count + 4'h1;
          if (bit_count == ADDR_LAST) begin
            state <= st_ta;
            bit_count <= '0;
            reg_addr <= next_addr[4:0];
            is_read <= (opcode == OP_READ) &&
                       (next_addr[9:5] == phy_address);
          end
        end
        st_ta: begin
          bit_count <= bit_count + 4'h1;
          if (bit_count == TA_LAST) begin
            state <= st_data;
            bit_count <= '0;
          end
        end
        // write data is clocked through and dropped
        st_data: begin
          bit_count <= bit_count + 4'h1;
          if (bit_count == DATA_LAST) begin
            state <= st_idle;
            bit_count <= '0;
            is_read <= 1'h0;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // read completes when the station samples the last data bit
  assign read_done = mdc_rise && state == st_data &&
                     bit_count == DATA_LAST && is_read &&
                     reg_addr == REG_STATUS;

  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!core_rstn) begin
      an_done <= 1'h0;
    end else begin
      an_done <= link_in.an_complete;
    end
  end

  // a fault arriving with the clearing read is kept
  always_ff @(posedge clk) begin
    if (!core_rstn) begin
      remote_fault <= 1'h0;
    end else if (link_in.remote_fault) begin
      remote_fault <= 1'h1;
    end else if (read_done) begin
      remote_fault <= 1'h0;
    end
  end

  // latch low, reload on read; station must read twice
  always_ff @(posedge clk) begin
    if (!core_rstn) begin
      link_status <= 1'h0;
    end else if (read_done) begin
      link_status <= link_ok;
    end else if (!link_ok) begin
      link_status <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // read mux and output driver
  // ----------------------------------------------------------------
  always_comb begin
    read_word = '0; // undefined addresses read zero
    case (reg_addr)
      REG_STATUS: begin
        read_word = STATUS_FIXED;
        read_word[AN_DONE_BIT] = an_done;
        read_word[RFAULT_BIT] = remote_fault;
        read_word[LINK_BIT] = link_status;
      end
      REG_ID_UPPER: begin
        read_word = org_id[21:ORG_UPPER_LO];
      end
      REG_ID_LOWER: begin
        read_word = {org_id[ORG_UPPER_LO-1:0], model_number, revision};
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // snapshot at turnaround so the clearing read sees old values
  always_ff @(posedge clk) begin
    if (!core_rstn) begin
      read_shift <= '0;
      management_frame_out <= 1'h0;
      management_frame_oe <= 1'h0;
    end else if (mdc_rise) begin
      if (state == st_ta && is_read) begin
        if (bit_count == TA_LAST) begin
          management_frame_out <= read_word[15];
          read_shift <= {read_word[14:0], 1'h0};
        end else begin
          management_frame_out <= 1'h0;
          management_frame_oe <= 1'h1;
        end
      end else if (state == st_data && is_read) begin
        if (bit_count == DATA_LAST) begin
          management_frame_oe <= 1'h0;
          management_frame_out <= 1'h0;
        end else begin
          management_frame_out <= read_shift[15];
          read_shift <= {read_shift[14:0], 1'h0};
        end
      end else begin
        management_frame_oe <= 1'h0;
        management_frame_out <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic status_snap;
  logic id_upper_snap;
  logic unmapped_snap;

  assign status_snap = mdc_rise && state == st_ta && is_read &&
                       bit_count == TA_LAST && reg_addr == REG_STATUS;
  assign id_upper_snap = mdc_rise && state == st_ta && is_read &&
                         bit_count == TA_LAST && reg_addr == REG_ID_UPPER;
  assign unmapped_snap = mdc_rise && state == st_ta && is_read &&
                         bit_count == TA_LAST && reg_addr > REG_ID_LOWER;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!core_rstn);

  a_ability_bits_zero: assert property (
    status_snap |=> !management_frame_out && read_shift[15:10] == '0)
    else $error("status ability bits not zero");

  a_fixed_ones: assert property (
    status_snap |=> read_shift[EXT_STATUS_BIT+1] &&
      read_shift[UNIDIR_BIT+1] && read_shift[PREAMBLE_SUPP_BIT+1] &&
      read_shift[AN_ABLE_BIT+1])
    else $error("status fixed one bits wrong");

  a_fixed_zeros: assert property (
    status_snap |=> read_shift[JABBER_BIT+1:EXT_CAP_BIT+1] == '0)
    else $error("jabber or extended capability not zero");

  a_clear_old_value: assert property (
    status_snap && remote_fault |=> read_shift[RFAULT_BIT+1])
    else $error("clearing read lost the fault value");

  a_ident_upper: assert property (
    id_upper_snap |=> {management_frame_out, read_shift[15:1]} ==
      org_id[21:ORG_UPPER_LO])
    else $error("identifier upper word wrong");

  a_unmapped_zero: assert property (
    unmapped_snap |=> !management_frame_out && read_shift == '0)
    else $error("unmapped address read not zero");

  a_an_done_follow: assert property (
    1'h1 |=> an_done == $past(link_in.an_complete))
    else $error("negotiation done bit not following");

  a_fault_sticky: assert property (
    remote_fault && !read_done |=> remote_fault)
    else $error("remote fault cleared without read");

  a_fault_clear: assert property (
    read_done && !link_in.remote_fault |=> !remote_fault)
    else $error("remote fault not cleared by read");

  a_link_latch_low: assert property (
    !link_ok && !read_done |=> !link_status ##1 (!link_status || $past(
      read_done)))
    else $error("link status not latched low");

  a_link_reload: assert property (
    read_done |=> link_status == $past(link_ok))
    else $error("read did not reload link status");

  a_reset_defaults: assert property (
    @(posedge clk) disable iff (!resetn)
    !core_rstn |=> !link_status && !remote_fault && !an_done &&
      !management_frame_oe)
    else $error("reset source did not restore defaults");

  c_status_read: cover property (read_done);
  c_fault_cleared: cover property (remote_fault ##1 read_done ##1
    !remote_fault);
  c_link_up_read: cover property (read_done && link_ok ##1 link_status);
  c_ident_read: cover property (id_upper_snap);

endmodule // sgmii_mgmt_status_id_regs

/* mgmt_station.sv */
// management station model driving the serial management port
`timescale 1ns/10ps
module mgmt_station (
  input wire logic clk,
  output logic mdc,
  output logic mdi,
  input wire logic mdo,
  input wire logic oe
);
  logic host_en;
  logic hb;
  // ------------------------------------------------------------
  // shared data line
  // ------------------------------------------------------------
  // pull-up holds the line high when nobody drives it
  assign mdi = oe ? mdo : (host_en ? hb : 1'b1);
  initial begin
    mdc = 1'b0;
    host_en = 1'b0;
    hb = 1'b1;
  end
  // ------------------------------------------------------------
  // bit and frame tasks
  // ------------------------------------------------------------
  // line sampled just before the rise, so the device had a full phase
  task automatic bit_cycle(input logic en, input logic b,
    output logic s);
    @(negedge clk);
    s = mdi;
    mdc = 1'b1;
    host_en = en;
    hb = b;
    repeat (2) @(negedge clk);
    mdc = 1'b0;
    @(negedge clk);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
    input logic [4:0] reg_addr, input logic [15:0] wdata,
    output logic [15:0] rdata);
    logic [31:0] word;
    logic s;
    word = {2'b01, op, phy, reg_addr, 2'b10, wdata};
    rdata = 16'h0000;
    bit_cycle(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      // read turnaround and data are left to the device
      bit_cycle(!(op == 2'h2 && i < 18), word[i], s);
      if (i < 16) begin
        rdata[i] = s;
      end
    end
    bit_cycle(1'b0, 1'b1, s);
  endtask
endmodule // mgmt_station

/* tb_sgmii_mgmt_status_id_regs.sv */
// self-checking bench for the status and identifier registers
`timescale 1ns/10ps
`define CHK(name, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("wrong value %s expected %h seen %h", name, exp, got); \
    end \
  end
module tb_sgmii_mgmt_status_id_regs;
  import sgmii_mgmt_pkg::*;
  localparam int unsigned TIMER = 8;
  localparam logic [4:0] PHY = 5'h05;
  localparam int LIMIT = 10000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_lock = 1'b1;
  logic soft_reset = 1'b0;
  logic [4:0] phy_address = PHY;
  link_state_s link_in = '0;
  logic mdc, mdi, mdo, oe, link_status, remote_fault, an_done;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  mgmt_word_t d;
  // ------------------------------------------------------------
  // structure
  // ------------------------------------------------------------
  always #50 clk = ~clk;
  sgmii_mgmt_status_id_regs #(.link_timer_cycles(TIMER)) DUT (
    .clk(clk), .resetn(resetn), .clk_lock(clk_lock),
    .soft_reset(soft_reset), .phy_address(phy_address),
    .link_in(link_in), .management_frame_clk(mdc),
    .management_frame_in(mdi), .management_frame_out(mdo),
    .management_frame_oe(oe), .link_status(link_status),
    .remote_fault(remote_fault), .an_done(an_done));
  mgmt_station station (.clk(clk), .mdc(mdc), .mdi(mdi), .mdo(mdo),
    .oe(oe));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic rd(input logic [4:0] a, output mgmt_word_t v);
    station.frame(OP_READ, PHY, a, 16'h0000, v);
  endtask
  task automatic wr(input logic [4:0] a, input mgmt_word_t w);
    mgmt_word_t v;
    station.frame(2'h1, PHY, a, w, v);
  endtask
  task automatic close_out;
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // a hung frame would otherwise run forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_ident;
    rd(REG_STATUS, d);
    `CHK("status reset", STATUS_FIXED, d)
    rd(REG_ID_UPPER, d);
    `CHK("id upper", ORG_ID_DEFAULT[21:6], d)
    rd(REG_ID_LOWER, d);
    `CHK("id lower", {ORG_ID_DEFAULT[5:0], MODEL_DEFAULT,
      REVISION_DEFAULT}, d)
    rd(5'h1f, d);
    `CHK("unmapped", 16'h0000, d)
    // other port address: line stays at the pull-up level
    station.frame(OP_READ, PHY ^ 5'h01, REG_STATUS, 16'h0000, d);
    `CHK("foreign phy", 16'hffff, d)
  endtask
  task automatic t_link;
    link_in = 4'he;
    repeat (4) @(negedge clk);
    `CHK("an_done", 1'b1, an_done)
    rd(REG_STATUS, d);
    `CHK("link latched", STATUS_FIXED | 16'h0020, d)
    rd(REG_STATUS, d);
    `CHK("link reread", STATUS_FIXED | 16'h0024, d)
    link_in.an_complete = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("link no an", 1'b0, link_status)
    link_in.an_enable = 1'b0;
    rd(REG_STATUS, d);
    `CHK("an off first", STATUS_FIXED, d)
    rd(REG_STATUS, d);
    `CHK("an off second", STATUS_FIXED | 16'h0004, d)
  endtask
  task automatic t_sync;
    link_in.sync_status = 1'b0;
    repeat (TIMER - 3) @(negedge clk);
    link_in.sync_status = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("short loss", 1'b1, link_status)
    link_in.sync_status = 1'b0;
    repeat (TIMER + 4) @(negedge clk);
    `CHK("long loss", 1'b0, link_status)
    link_in.sync_status = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("held low", 1'b0, link_status)
    rd(REG_STATUS, d);
    `CHK("loss read", STATUS_FIXED, d)
    rd(REG_STATUS, d);
    `CHK("loss reread", STATUS_FIXED | 16'h0004, d)
  endtask
  task automatic t_fault;
    link_in.remote_fault = 1'b1;
    @(negedge clk);
    link_in.remote_fault = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("fault set", 1'b1, remote_fault)
    rd(REG_ID_UPPER, d);
    `CHK("fault kept", 1'b1, remote_fault)
    rd(REG_STATUS, d);
    `CHK("fault read", STATUS_FIXED | 16'h0014, d)
    `CHK("fault cleared", 1'b0, remote_fault)
    rd(REG_STATUS, d);
    `CHK("fault gone", STATUS_FIXED | 16'h0004, d)
  endtask
  task automatic t_writes;
    wr(REG_STATUS, 16'hffff);
    wr(REG_ID_UPPER, ~ORG_ID_DEFAULT[21:6]);
    wr(5'h1f, 16'hffff);
    rd(REG_STATUS, d);
    `CHK("status wr", STATUS_FIXED | 16'h0004, d)
    rd(REG_ID_UPPER, d);
    `CHK("id wr", ORG_ID_DEFAULT[21:6], d)
    rd(5'h1f, d);
    `CHK("unmapped wr", 16'h0000, d)
  endtask
  task automatic t_resets;
    for (int src = 0; src < 3; src++) begin
      link_in.remote_fault = 1'b1;
      @(negedge clk);
      link_in.remote_fault = 1'b0;
      case (src)
        0: resetn = 1'b0;
        1: clk_lock = 1'b0;
        default: soft_reset = 1'b1;
      endcase
      repeat (2) @(negedge clk);
      `CHK("rst fault", 1'b0, remote_fault)
      `CHK("rst link", 1'b0, link_status)
      resetn = 1'b1;
      clk_lock = 1'b1;
      soft_reset = 1'b0;
      repeat (3) @(negedge clk);
      rd(REG_STATUS, d);
      `CHK("after rst", STATUS_FIXED, d)
      rd(REG_STATUS, d);
      `CHK("after rst 2", STATUS_FIXED | 16'h0004, d)
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_ident();
    t_link();
    t_sync();
    t_fault();
    t_writes();
    t_resets();
    close_out();
  end
endmodule // tb_sgmii_mgmt_status_id_regs
